// ===== src/ascs_cfg.svh
`ifndef ASCS_CFG_SVH
`define ASCS_CFG_SVH
// register addresses within the internal register area
`define ASCS_ADDR_RATE_MODE   5'h10
`define ASCS_ADDR_CTRL_STATUS 5'h11
`define ASCS_ADDR_RX_DATA     5'h12
`define ASCS_ADDR_TX_DATA     5'h13
// control/status field positions
`define ASCS_BIT_WAKE   0
`define ASCS_BIT_TXON   1
`define ASCS_BIT_TXIE   2
`define ASCS_BIT_RXON   3
`define ASCS_BIT_RXIE   4
`define ASCS_BIT_TX_HOLDING_EMPTY   5
`define ASCS_BIT_RERR   6
`define ASCS_BIT_RFULL  7
`define ASCS_CS_RESET   8'h20
`define ASCS_CS_WMASK   8'h1f
`define ASCS_RM_RESET   4'h0
// internal dividers, in clocks per eighth of a bit
`define ASCS_DIV8_0     12'h002
`define ASCS_DIV8_1     12'h010
`define ASCS_DIV8_2     12'h080
`define ASCS_DIV8_3     12'h200
`define ASCS_PREAMBLE   4'h9
`define ASCS_IDLE_ONES  4'ha
`define ASCS_FRAME_BITS 4'ha
`define ASCS_FIFO_DEPTH 4
`endif

// ===== src/ascs_pkg.sv
package ascs_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ascs_bus_t;
    typedef struct packed {
        logic clk_out;
        logic clk_oe;
        logic txd;
        logic txd_oe;
    } ascs_pins_t;
    typedef enum logic [1:0] {
        ASCS_TX_IDLE = 2'b00,
        ASCS_TX_PRE  = 2'b01,
        ASCS_TX_SEND = 2'b10
    } ascs_tx_t;
    typedef enum logic [1:0] {
        ASCS_RX_IDLE  = 2'b00,
        ASCS_RX_START = 2'b01,
        ASCS_RX_DATA  = 2'b10
    } ascs_rx_t;
endpackage

// ===== src/ascs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ascs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic [AW-1:0]    next_wp;
    logic [AW-1:0]    next_rp;
    logic [AW:0]      next_cnt;
    logic             push;
    logic             pop;
    // honest flags straight from the count
    assign in_ready  = (cnt != DEPTH[AW:0]);
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // pointer and count update
    always_comb begin
        next_wp  = push ? wp + 1'b1 : wp;
        next_rp  = pop ? rp + 1'b1 : rp;
        next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
        end
    end
    // storage needs no reset, it is gated by the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== src/ascs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascs_cfg.svh"
module ascs_top (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // internal register bus
    input  wire ascs_pkg::ascs_bus_t bus,
    output logic           [7:0] rdata,
    // port 2 lines
    input  wire logic            p2_rxd,
    input  wire logic            p2_clk_in,
    output ascs_pkg::ascs_pins_t pins,
    // shared interrupt line
    output logic                 periph_irq_line
);
    import ascs_pkg::*;
    logic [7:0] cs;
    logic [3:0] rm;
    logic [7:0] rx_data;
    logic       armed;
    logic [7:0] next_cs;
    logic [3:0] next_rm;
    logic [7:0] next_rx_data;
    logic       next_armed;
    logic [7:0] next_rdata;
    logic       next_irq;
    ascs_pins_t next_pins;
    // two-flop synchronisers for pin inputs
    logic [1:0] rxd_s;
    logic [1:0] eck_s;
    logic       eck_d;
    // tick generation
    logic [11:0] div;
    logic [11:0] next_div;
    logic [2:0]  sub;
    logic [2:0]  next_sub;
    logic        tick8;
    logic        bit_tick;
    logic [11:0] div_lim;
    // transmitter
    ascs_tx_t   tx_st;
    ascs_tx_t   next_tx_st;
    logic [8:0] tx_sh;
    logic [8:0] next_tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] next_tx_cnt;
    logic       fifo_out_valid;
    logic       fifo_in_ready;
    logic [7:0] fifo_out_data;
    logic       tx_take;
    // receiver
    ascs_rx_t   rx_st;
    ascs_rx_t   next_rx_st;
    logic [2:0] rx_ph;
    logic [2:0] next_rx_ph;
    logic [3:0] rx_cnt;
    logic [3:0] next_rx_cnt;
    logic [7:0] rx_sh;
    logic [7:0] next_rx_sh;
    logic [3:0] ones;
    logic [3:0] next_ones;
    logic       rx_in;
    logic       rx_done_ok;
    logic       rx_done_bad;
    logic       wr_tx;
    logic       rd_cs;
    logic       rd_rx;

    assign wr_tx = bus.wr && bus.addr == `ASCS_ADDR_TX_DATA;
    assign rd_cs = bus.rd && bus.addr == `ASCS_ADDR_CTRL_STATUS;
    assign rd_rx = bus.rd && bus.addr == `ASCS_ADDR_RX_DATA;

    // pin synchronisers, only the second stage is read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxd_s <= 2'h3;
            eck_s <= 2'h0;
            eck_d <= 1'b0;
        end else begin
            rxd_s <= {rxd_s[0], p2_rxd};
            eck_s <= {eck_s[0], p2_clk_in};
            eck_d <= eck_s[1];
        end
    end
    // line 3 reaches the receiver only while rx on, else idle high
    assign rx_in = cs[`ASCS_BIT_RXON] ? rxd_s[1] : 1'b1;

    // divider table; each entry is a clock count per eighth of a bit
    always_comb begin
        case (rm[1:0])
            2'b00:   div_lim = `ASCS_DIV8_0;
            2'b01:   div_lim = `ASCS_DIV8_1;
            2'b10:   div_lim = `ASCS_DIV8_2;
            default: div_lim = `ASCS_DIV8_3;
        endcase
    end
    // one shared x8 tick keeps both directions on the same rate
    always_comb begin
        next_div = div;
        tick8    = 1'b0;
        if (rm[3:2] == 2'b11) begin
            tick8 = eck_s[1] && !eck_d;
        end else if (rm[3:2] != 2'b00) begin
            if (div == div_lim - 12'h001) begin
                next_div = 12'h000;
                tick8    = 1'b1;
            end else begin
                next_div = div + 12'h001;
            end
        end
        next_sub = tick8 ? sub + 3'h1 : sub;
        bit_tick = tick8 && sub == 3'h7;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div <= 12'h000;
            sub <= 3'h0;
        end else begin
            div <= next_div;
            sub <= next_sub;
        end
    end

    // transmitter; data writes to a full fifo are dropped
    assign tx_take = bit_tick && tx_st == ASCS_TX_IDLE && tx_cnt == 4'h0
                     && fifo_out_valid;
    always_comb begin
        next_tx_st  = tx_st;
        next_tx_sh  = tx_sh;
        next_tx_cnt = tx_cnt;
        if (!cs[`ASCS_BIT_TXON]) begin
            next_tx_st  = ASCS_TX_PRE;
            next_tx_cnt = `ASCS_PREAMBLE;
            next_tx_sh  = 9'h1ff;
        end else if (bit_tick) begin
            case (tx_st)
                ASCS_TX_PRE: begin
                    next_tx_cnt = tx_cnt - 4'h1;
                    if (tx_cnt == 4'h1) begin
                        next_tx_st = ASCS_TX_IDLE;
                    end
                end
                ASCS_TX_IDLE: begin
                    next_tx_cnt = 4'h0;
                    if (fifo_out_valid) begin
                        next_tx_sh  = {fifo_out_data, 1'b0};
                        next_tx_cnt = `ASCS_FRAME_BITS - 4'h1;
                        next_tx_st  = ASCS_TX_SEND;
                    end
                end
                ASCS_TX_SEND: begin
                    next_tx_sh  = {1'b1, tx_sh[8:1]};
                    next_tx_cnt = tx_cnt - 4'h1;
                    if (tx_cnt == 4'h1) begin
                        next_tx_st = ASCS_TX_IDLE;
                    end
                end
                default: next_tx_st = ASCS_TX_PRE;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_st  <= ASCS_TX_PRE;
            tx_sh  <= 9'h1ff;
            tx_cnt <= `ASCS_PREAMBLE;
        end else begin
            tx_st  <= next_tx_st;
            tx_sh  <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
        end
    end
    ascs_fifo #(.WIDTH(8), .DEPTH(`ASCS_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_tx),
        .in_ready  (fifo_in_ready),
        .in_data   (bus.wdata),
        .out_valid (fifo_out_valid),
        .out_ready (tx_take),
        .out_data  (fifo_out_data)
    );

    // receiver: start found on first zero, sampled at sub-phase 4
    always_comb begin
        next_rx_st  = rx_st;
        next_rx_ph  = rx_ph;
        next_rx_cnt = rx_cnt;
        next_rx_sh  = rx_sh;
        next_ones   = ones;
        rx_done_ok  = 1'b0;
        rx_done_bad = 1'b0;
        if (tick8) begin
            next_rx_ph = rx_ph + 3'h1;
            case (rx_st)
                ASCS_RX_IDLE: begin
                    if (!rx_in) begin
                        next_rx_st = ASCS_RX_START;
                        next_rx_ph = 3'h1;
                    end
                end
                ASCS_RX_START: begin
                    // fourth eighth after the first zero is near the bit centre
                    if (rx_ph == 3'h4) begin
                        next_rx_st  = rx_in ? ASCS_RX_IDLE : ASCS_RX_DATA;
                        next_rx_cnt = 4'h0;
                    end
                end
                ASCS_RX_DATA: begin
                    if (rx_ph == 3'h4) begin
                        next_rx_cnt = rx_cnt + 4'h1;
                        if (rx_cnt == 4'h8) begin
                            next_rx_st  = ASCS_RX_IDLE;
                            rx_done_ok  = rx_in;
                            rx_done_bad = !rx_in;
                        end else begin
                            next_rx_sh = {rx_in, rx_sh[7:1]};
                        end
                    end
                end
                default: next_rx_st = ASCS_RX_IDLE;
            endcase
        end
        // idle detector counts ones sampled once per bit, on bit_tick
        if (bit_tick) begin
            next_ones = !rx_in ? 4'h0 :
                        (ones == `ASCS_IDLE_ONES) ? ones : ones + 4'h1;
        end
        // restart the count on a status write; wake written while ones already reads ten is still cleared at once
        if (bus.wr && bus.addr == `ASCS_ADDR_CTRL_STATUS) begin
            next_ones = 4'h0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_st  <= ASCS_RX_IDLE;
            rx_ph  <= 3'h0;
            rx_cnt <= 4'h0;
            rx_sh  <= 8'h00;
            ones   <= 4'h0;
        end else begin
            rx_st  <= next_rx_st;
            rx_ph  <= next_rx_ph;
            rx_cnt <= next_rx_cnt;
            rx_sh  <= next_rx_sh;
            ones   <= next_ones;
        end
    end

    // registers; hardware sets win over the read-sequence clears
    always_comb begin
        next_cs      = cs;
        next_rm      = rm;
        next_rx_data = rx_data;
        next_armed   = armed;
        if (rd_cs) begin
            next_armed = 1'b1;
        end
        if (bus.wr && bus.addr == `ASCS_ADDR_CTRL_STATUS) begin
            next_cs = (cs & ~`ASCS_CS_WMASK) | (bus.wdata & `ASCS_CS_WMASK);
        end
        if (bus.wr && bus.addr == `ASCS_ADDR_RATE_MODE) begin
            next_rm = bus.wdata[3:0];
        end
        if (wr_tx && armed) begin
            next_cs[`ASCS_BIT_TX_HOLDING_EMPTY] = 1'b0;
            next_armed = 1'b0;
        end
        if (rd_rx && armed) begin
            next_cs[`ASCS_BIT_RFULL] = 1'b0;
            next_cs[`ASCS_BIT_RERR]  = 1'b0;
            next_armed = 1'b0;
        end
        if (tx_take) begin
            next_cs[`ASCS_BIT_TX_HOLDING_EMPTY] = 1'b1;
        end
        if (rx_done_ok) begin
            next_rx_data = rx_sh;
            next_cs[`ASCS_BIT_RFULL] = 1'b1;
            if (cs[`ASCS_BIT_RFULL]) begin
                next_cs[`ASCS_BIT_RERR] = 1'b1;
            end
        end
        if (rx_done_bad) begin
            next_cs[`ASCS_BIT_RERR] = 1'b1;
        end
        if (ones == `ASCS_IDLE_ONES || !next_cs[`ASCS_BIT_RXON]) begin
            next_cs[`ASCS_BIT_WAKE] = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs      <= `ASCS_CS_RESET;
            rm      <= `ASCS_RM_RESET;
            rx_data <= 8'h00;
            armed   <= 1'b0;
        end else begin
            cs      <= next_cs;
            rm      <= next_rm;
            rx_data <= next_rx_data;
            armed   <= next_armed;
        end
    end

    // registered read data, interrupt and pins
    always_comb begin
        case (bus.addr)
            `ASCS_ADDR_CTRL_STATUS: next_rdata = next_cs;
            `ASCS_ADDR_RX_DATA:     next_rdata = next_rx_data;
            default:                next_rdata = 8'h00; // write-only reads zero
        endcase
        next_irq = (next_cs[`ASCS_BIT_TXIE] && next_cs[`ASCS_BIT_TX_HOLDING_EMPTY])
                   || (next_cs[`ASCS_BIT_RXIE] && !next_cs[`ASCS_BIT_WAKE]
                       && (next_cs[`ASCS_BIT_RFULL] || next_cs[`ASCS_BIT_RERR]));
        next_pins.txd     = next_tx_sh[0] || next_tx_st != ASCS_TX_SEND;
        next_pins.txd_oe  = next_cs[`ASCS_BIT_TXON];
        next_pins.clk_oe  = next_rm[3:2] == 2'b10;
        // rising edge at mid-bit
        next_pins.clk_out = next_sub[2];
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata           <= 8'h00;
            periph_irq_line <= 1'b0;
            pins            <= '{clk_out: 1'b0, clk_oe: 1'b0, txd: 1'b1, txd_oe: 1'b0};
        end else begin
            rdata           <= next_rdata;
            periph_irq_line <= next_irq;
            pins            <= next_pins;
        end
    end
endmodule
`default_nettype wire

// ===== sim/ascs_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascs_cfg.svh"
module ascs_top_properties (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // register bus side
    input wire ascs_pkg::ascs_bus_t  bus,
    input wire logic           [7:0] rdata,
    // pins and interrupt
    input wire ascs_pkg::ascs_pins_t pins,
    input wire logic                 periph_irq_line
);
    import ascs_pkg::*;
    logic [4:0] ctl;
    logic [4:0] next_ctl;
    logic       sent;
    logic       next_sent;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // software view of control bits; hardware clear of wake bit not mirrored
    always_comb begin
        next_ctl = ctl;
        next_sent = sent;
        if (bus.wr && bus.addr == `ASCS_ADDR_CTRL_STATUS)
            next_ctl = bus.wdata[4:0];
        if (bus.wr && bus.addr == `ASCS_ADDR_TX_DATA)
            next_sent = 1'b1;
        if (sys_rst) begin
            next_ctl = 5'h00;
            next_sent = 1'b0;
        end
    end
    // mirror registers only
    always_ff @(posedge clk) begin
        ctl <= next_ctl;
        sent <= next_sent;
    end
    // reset itself is the cause here, so no disable
    property p_rst_quiet;
        disable iff (1'b0) sys_rst |=> rdata == 8'h00 && !periph_irq_line
            && !pins.txd_oe && !pins.clk_oe;
    endproperty
    sequence s_tx_up;
        $rose(pins.txd_oe);
    endsequence
    sequence s_mark8;
        pins.txd [*8];
    endsequence
    sequence s_low_edge;
        pins.txd_oe && $past(pins.txd_oe) && $fell(pins.txd);
    endsequence
    property p_preamble;
        s_tx_up |-> s_mark8;
    endproperty
    property p_start;
        s_low_edge |-> (!pins.txd) [*8];
    endproperty
    property p_txoe_on;
        ctl[1] [*3] |-> pins.txd_oe;
    endproperty
    property p_txoe_off;
        (!ctl[1]) [*3] |-> !pins.txd_oe;
    endproperty
    property p_irq_masked;
        (!ctl[2] && !ctl[4]) [*3] |-> !periph_irq_line;
    endproperty
    property p_irq_tx;
        (ctl[2] && !sent) [*3] |-> periph_irq_line;
    endproperty
    property p_rd_quiet;
        bus.rd && (bus.addr == `ASCS_ADDR_RATE_MODE || bus.addr == `ASCS_ADDR_TX_DATA)
            |=> rdata == 8'h00;
    endproperty
    property p_rd_ctl;
        bus.rd && bus.addr == `ASCS_ADDR_CTRL_STATUS |=> rdata[4:1] == ctl[4:1];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy in reset");
    a_preamble: assert property (p_preamble) else $error("preamble not mark");
    a_start: assert property (p_start) else $error("low bit too short");
    a_txoe_on: assert property (p_txoe_on) else $error("line not driven");
    a_txoe_off: assert property (p_txoe_off) else $error("line driven while off");
    a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
    a_irq_tx: assert property (p_irq_tx) else $error("no irq for empty holding");
    a_rd_quiet: assert property (p_rd_quiet) else $error("write-only read not 0");
    a_rd_ctl: assert property (p_rd_ctl) else $error("control bits misread");
endmodule
`default_nettype wire

// ===== sim/ascs_remote.sv
`timescale 1ns/1ps
`default_nettype none
module ascs_remote #(
    parameter int BIT = 16
) (
    // clock
    input  wire logic clk,
    // line from the device
    input  wire logic txd,
    input  wire logic txd_oe,
    // line into the device
    output logic      rxd
);
    logic [7:0] got [$];
    logic [7:0] shift;
    logic       line;
    // pull-up holds mark while the device lets go of the line
    assign line = txd_oe ? txd : 1'b1;
    initial rxd = 1'b1;
    // one frame with a chosen stop level, then an idle gap before the next message
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (BIT) @(negedge clk);
        end
        rxd = 1'b1;
        repeat (2 * BIT) @(negedge clk);
    endtask
    // mid-bit sampling; frames with a bad stop bit are thrown away
    initial begin
        forever begin
            @(negedge line);
            repeat (BIT / 2) @(posedge clk);
            if (!line) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk);
                    shift[i] = line;
                end
                repeat (BIT) @(posedge clk);
                if (line)
                    got.push_back(shift);
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/async_serial_control_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascs_cfg.svh"
module async_serial_control_status_bench;
    import ascs_pkg::*;
    localparam logic [4:0] RM = `ASCS_ADDR_RATE_MODE;
    localparam logic [4:0] CS = `ASCS_ADDR_CTRL_STATUS;
    localparam logic [4:0] RX = `ASCS_ADDR_RX_DATA;
    localparam logic [4:0] TX = `ASCS_ADDR_TX_DATA;
    logic       clk;
    logic       sys_rst;
    ascs_bus_t  bus;
    logic [7:0] rdata;
    logic       p2_rxd;
    ascs_pins_t pins;
    logic       periph_irq_line;
    logic [7:0] v;
    int         mismatches;
    int         check_count;

    ascs_top dut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .p2_rxd(p2_rxd),
                  .p2_clk_in(1'b0), .pins(pins), .periph_irq_line(periph_irq_line));
    ascs_remote #(.BIT(16)) far (.clk(clk), .txd(pins.txd), .txd_oe(pins.txd_oe), .rxd(p2_rxd));

    // 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // bus cycles: one-cycle strobe, read data taken the cycle after
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = {1'b1, 1'b0, a, d};
        @(negedge clk);
        bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        bus = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        d = rdata;
        bus.rd = 1'b0;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [4:0] a, input logic [7:0] e);
        rd(a, v);
        chk(n, e, v);
    endtask
    // bounded wait for bytes at the far end
    task automatic wait_got(input int n);
        for (int i = 0; i < 3000 && far.got.size() < n; i++)
            @(negedge clk);
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the whole run is eleven frames; this is several times that
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        mismatches = 0;
        check_count = 0;
        bus = '0;
        sys_rst = 1'b1;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        // reset values, write-only and unmapped places
        rdchk("status", CS, 8'h20);
        rdchk("rate_mode", RM, 8'h00);
        rdchk("tx_data", TX, 8'h00);
        rdchk("unmapped", 5'h15, 8'h00);
        wr(CS, 8'hf4);
        rdchk("status_wr", CS, 8'h34);
        chk("irq_tx", 8'h01, {7'h0, periph_irq_line});
        wr(CS, 8'h10);
        repeat (2) @(negedge clk);
        chk("irq_masked", 8'h00, {7'h0, periph_irq_line});
        // clock pin claimed only by the clock-out code
        for (int m = 0; m < 4; m++) begin
            wr(RM, {4'h0, m[1:0], 2'b00});
            repeat (2) @(negedge clk);
            chk("clk_oe", {7'h0, m == 2}, {7'h0, pins.clk_oe});
        end
        wr(RM, 8'h04);
        repeat (16) @(negedge clk);
        wr(CS, 8'h0a);
        rd(CS, v);
        wr(TX, 8'ha5);
        rdchk("tx_holding_empty_clear", CS, 8'h0a);
        wait_got(1);
        chk("tx_byte", 8'ha5, far.got.pop_front());
        rdchk("tx_holding_empty_set", CS, 8'h2a);
        // back-to-back: shifter takes one, fifo keeps four, the sixth is dropped
        // let the shifter take the first byte before the rest arrive
        for (int i = 0; i < 6; i++) begin
            wr(TX, 8'h30 + i[7:0]);
            if (i == 0)
                repeat (20) @(negedge clk);
        end
        wait_got(5);
        repeat (300) @(negedge clk);
        chk("burst_count", 8'h05, 8'(far.got.size()));
        for (int i = 0; i < 5; i++)
            chk("burst_byte", 8'h30 + i[7:0], far.got.pop_front());
        // receive, then status read and data read
        far.send(8'h3c, 1'b1);
        rdchk("rx_full", CS, 8'haa);
        rdchk("rx_data", RX, 8'h3c);
        rdchk("rx_clear", CS, 8'h2a);
        far.send(8'h55, 1'b0);
        repeat (200) @(negedge clk);
        rd(CS, v);
        chk("frame_err", 8'h40, v & 8'h40);
        rd(RX, v);
        far.send(8'h11, 1'b1);
        far.send(8'h22, 1'b1);
        rd(CS, v);
        chk("overrun", 8'hc0, v & 8'hc0);
        rd(RX, v);
        rdchk("err_clear", CS, 8'h2a);
        // wake-wait hides the receive irq until ten idle bits
        wr(CS, 8'h1b);
        far.send(8'h5a, 1'b1);
        chk("irq_wake", 8'h00, {7'h0, periph_irq_line});
        rdchk("wake_set", CS, 8'hbb);
        repeat (200) @(negedge clk);
        chk("irq_rx", 8'h01, {7'h0, periph_irq_line});
        rdchk("wake_clr", CS, 8'hba);
        rd(RX, v);
        repeat (2) @(negedge clk);
        chk("irq_rx_off", 8'h00, {7'h0, periph_irq_line});
        wrap_up();
    end
endmodule
bind ascs_top ascs_top_properties u_props (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .rdata(rdata), .pins(pins), .periph_irq_line(periph_irq_line));
`default_nettype wire
